// File: common/dipsp_map.svh
/*
  Constants of the dual paged I2C slave port: slave addresses, page layout,
  controller register offsets, field positions and bit-rate counts.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef DIPSP_MAP_SVH
`define DIPSP_MAP_SVH

// ==========================================================================
// Timing
`define DIPSP_CLK_HZ 25000000
`define DIPSP_STD_BPS 100000
`define DIPSP_FAST_BPS 400000
`define DIPSP_HS_BPS 3400000
// Least quarter-bit time in clock cycles for a bit rate, rounded up
`define DIPSP_QTR(bps) ((((`DIPSP_CLK_HZ + (bps) - 1) / (bps)) + 3) / 4)

// ==========================================================================
// Slave addresses and pages
`define DIPSP_CFG_BASE 7'h48
`define DIPSP_CFG_ALT 7'h58
`define DIPSP_SCALE_ADDR 7'h12
`define DIPSP_HS_CODE 5'h01
`define DIPSP_UNDEF_BYTE 8'hFF
`define DIPSP_PAGES 5
`define DIPSP_DEF_BITS 4
`define DIPSP_SCALE_PAGE 3'h4
`define DIPSP_REMAP_PAGE 3'h1
`define DIPSP_REMAP_OFS 8'h00
`define DIPSP_REMAP_RST 8'h00

// ==========================================================================
// Controller registers
`define DIPSP_CTRL_OFS 12'h000
`define DIPSP_CMD_OFS 12'h004
`define DIPSP_STAT_OFS 12'h008
`define DIPSP_CMD_ACKN_BIT 11
`define DIPSP_CMD_OP_LSB 8

`endif

// File: common/dipsp_pkg.sv
/*
  Types of the dual paged I2C slave port: state and command enumerations.
  Assumes nothing of its surroundings.
*/
package dipsp_pkg;
  typedef enum logic [4:0] {
    ds_idle = 5'h01,
    ds_addr = 5'h02,
    ds_wr = 5'h04,
    ds_rd = 5'h08,
    ds_skip = 5'h10
  } dipsp_dev_state_t;

  typedef enum logic [3:0] {
    ms_idle = 4'h1,
    ms_start = 4'h2,
    ms_stop = 4'h4,
    ms_byte = 4'h8
  } dipsp_host_state_t;

  typedef enum logic [2:0] {
    op_none = 3'h0,
    op_start = 3'h1,
    op_stop = 3'h2,
    op_write = 3'h3,
    op_read = 3'h4
  } dipsp_op_t;

  typedef logic [1:0] dipsp_port_vec_t;
endpackage : dipsp_pkg

// File: common/dipsp_link_if.sv
/*
  Two open-drain I2C links, index 0 the config port, index 1 the scaling port.
  Assumes pull-ups: a line is low only while some party drives it low.
*/
`timescale 1ns/10ps
`default_nettype none
interface dipsp_link_if;
  logic [1:0] host_scl_o;
  logic [1:0] host_scl_oe;
  logic [1:0] host_sda_o;
  logic [1:0] host_sda_oe;
  logic [1:0] dev_sda_o;
  logic [1:0] dev_sda_oe;
  wire logic config_port_clock_pin;
  wire logic config_port_data_pin;
  wire logic scaling_port_clock_pin;
  wire logic scaling_port_data_pin;
  wire logic [1:0] scl_lvl;
  wire logic [1:0] sda_lvl;

  // ========================================================================
  // Wired-AND resolution
  assign config_port_clock_pin = !(host_scl_oe[0] && !host_scl_o[0]);
  assign scaling_port_clock_pin = !(host_scl_oe[1] && !host_scl_o[1]);
  assign config_port_data_pin = !((host_sda_oe[0] && !host_sda_o[0]) ||
                                  (dev_sda_oe[0] && !dev_sda_o[0]));
  assign scaling_port_data_pin = !((host_sda_oe[1] && !host_sda_o[1]) ||
                                   (dev_sda_oe[1] && !dev_sda_o[1]));
  assign scl_lvl = {scaling_port_clock_pin, config_port_clock_pin};
  assign sda_lvl = {scaling_port_data_pin, config_port_data_pin};

  modport device (input scl_lvl, input sda_lvl, output dev_sda_o, output dev_sda_oe);
  modport host (input scl_lvl, input sda_lvl, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface : dipsp_link_if
`default_nettype wire

// File: hdl/dipsp_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/10ps
`default_nettype none
module dipsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // ========================================================================
  // Only the second stage may be read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : dipsp_sync
`default_nettype wire

// File: hdl/dipsp_device.sv
/*
  Device end: two independent I2C slave engines over a paged register store.
  Assumes the link lines and the factory select strap are asynchronous pins,
  and that the bus clock is at least a few pclk cycles per phase.
*/
// Summary of operation
// - I2C ports live only when factory select high
// - Scaling port reaches only the scaling page
// - Ports run independently, never blocking each other
// - Slave only; never drives clock
// - Standard, fast and high-speed rates supported
// - Only 7-bit addresses; no general call
// - Config address upper bits fixed, low two pick page
// - Five pages of 16 bytes, own addresses
// - Scaling port has one fixed address
// - Remap bits move page addresses to alternatives
// - START detected, address reception begins
// - Master keeps SDA stable while SCL high
// - Acknowledge matching address through ninth high phase
// - Direction bit one writes, zero reads
// - Receiver acknowledges every byte; bytes repeat
// - STOP releases bus, waits for START
// - Undefined locations read as all ones
// - Master code switches to high speed, unacknowledged
// - Repeated START keeps high speed; STOP leaves
`timescale 1ns/10ps
`default_nettype none
`include "dipsp_map.svh"
module dipsp_device #(
  parameter int DEF_BITS = `DIPSP_DEF_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic factory_i2c_sel,
  dipsp_link_if.device link,
  output logic [3:0] page_addr_remap_bits,
  output var dipsp_pkg::dipsp_port_vec_t hs_mode
);
  import dipsp_pkg::*;

  localparam int DEF_LEN = 1 << DEF_BITS;
  localparam int MEM_N = `DIPSP_PAGES * DEF_LEN;

  logic sel_s;
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [1:0] scl_p;
  logic [1:0] sda_p;
  logic i2c_on_q;
  logic [7:0] remap_q;
  logic [7:0] mem [0:MEM_N-1];
  wire [1:0] wr_en;
  wire [1:0][2:0] wr_pg;
  wire [1:0][7:0] wr_off;
  wire [1:0][7:0] wr_dat;

  // ==========================================================================
  // Pin sampling
  dipsp_sync #(.W(5), .INIT(5'h0F)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({factory_i2c_sel, link.sda_lvl, link.scl_lvl}),
    .q({sel_s, sda_s, scl_s})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_p <= 2'h3;
      sda_p <= 2'h3;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  // The SPI variant is not built; with select low both ports stay silent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i2c_on_q <= 1'b0;
    end else begin
      i2c_on_q <= sel_s;
    end
  end

  // ==========================================================================
  // Register store
  function automatic logic [7:0] rd_byte(input logic [2:0] pg, input logic [7:0] off);
    rd_byte = `DIPSP_UNDEF_BYTE;
    if (pg == `DIPSP_REMAP_PAGE && off == `DIPSP_REMAP_OFS) begin
      rd_byte = remap_q;
    end else if (off < 8'(DEF_LEN)) begin
      rd_byte = mem[{pg, off[DEF_BITS-1:0]}];
    end
  endfunction : rd_byte

  // The two ports never share a page, so both may write in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < MEM_N; k++) begin
        mem[k] <= 8'h00;
      end
      remap_q <= `DIPSP_REMAP_RST;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (wr_en[p]) begin
          if (wr_pg[p] == `DIPSP_REMAP_PAGE && wr_off[p] == `DIPSP_REMAP_OFS) begin
            remap_q <= {3'h0, wr_dat[p][4:0]};
          end else if (wr_off[p] < 8'(DEF_LEN)) begin
            mem[{wr_pg[p], wr_off[p][DEF_BITS-1:0]}] <= wr_dat[p];
          end
        end
      end
    end
  end

  assign page_addr_remap_bits = remap_q[3:0];

  // ==========================================================================
  // Slave engines, one per port
  for (genvar i = 0; i < 2; i++) begin : g_port
    dipsp_dev_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] off_q;
    logic [7:0] tx_q;
    logic [2:0] pg_q;
    logic first_q;
    logic rw_q;
    logic drv_q;
    logic hs_q;
    logic hit;
    logic [2:0] hit_pg;
    logic [7:0] rbyte;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    assign rise = scl_s[i] && !scl_p[i];
    assign fall = !scl_s[i] && scl_p[i];
    assign start = scl_s[i] && scl_p[i] && sda_p[i] && !sda_s[i];
    assign stop = scl_s[i] && scl_p[i] && !sda_p[i] && sda_s[i];
    assign rbyte = rd_byte(pg_q, off_q);

    if (i == 0) begin : g_cfg
      always_comb begin
        hit = 1'b0;
        hit_pg = 3'h0;
        for (int k = 0; k < 4; k++) begin
          if (sh_q[7:1] == (remap_q[k] ? `DIPSP_CFG_ALT : `DIPSP_CFG_BASE) + 7'(k)) begin
            hit = 1'b1;
            hit_pg = 3'(k);
          end
        end
      end
    end else begin : g_scale
      assign hit = (sh_q[7:1] == `DIPSP_SCALE_ADDR);
      assign hit_pg = `DIPSP_SCALE_PAGE;
    end

    assign wr_en[i] = fall && st_q == ds_wr && cnt_q == 4'h7 && !first_q;
    assign wr_pg[i] = pg_q;
    assign wr_off[i] = off_q;
    assign wr_dat[i] = sh_q;

    // Bits are taken on SCL rise and driven after SCL fall; SCL is only read
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_q <= ds_idle;
        cnt_q <= 4'h0;
        sh_q <= 8'h00;
        off_q <= 8'h00;
        tx_q <= 8'hFF;
        pg_q <= 3'h0;
        first_q <= 1'b0;
        rw_q <= 1'b0;
        drv_q <= 1'b0;
        hs_q <= 1'b0;
      end else if (!i2c_on_q || stop) begin
        st_q <= ds_idle;
        cnt_q <= 4'h0;
        drv_q <= 1'b0;
        hs_q <= 1'b0;
      end else if (start) begin
        st_q <= ds_addr;
        cnt_q <= 4'hF; // The START's own SCL fall wraps this to zero
        drv_q <= 1'b0;
        first_q <= 1'b1;
      end else if (rise) begin
        case (st_q)
          ds_addr, ds_wr: begin
            if (cnt_q != 4'h8) begin
              sh_q <= {sh_q[6:0], sda_s[i]};
            end
          end
          ds_rd: begin
            if (cnt_q == 4'h8) begin
              if (sda_s[i]) begin
                st_q <= ds_skip;
              end else begin
                off_q <= off_q + 8'h01;
              end
            end
          end
          default: begin
          end
        endcase
      end else if (fall) begin
        case (st_q)
          ds_addr: begin
            if (cnt_q == 4'h7) begin
              cnt_q <= 4'h8;
              if (sh_q[7:3] == `DIPSP_HS_CODE) begin
                hs_q <= 1'b1;
                st_q <= ds_skip;
              end else if (hit) begin
                drv_q <= 1'b1;
                pg_q <= hit_pg;
                rw_q <= sh_q[0];
              end else begin
                st_q <= ds_skip;
              end
            end else if (cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (rw_q) begin
                st_q <= ds_wr;
                drv_q <= 1'b0;
              end else begin
                st_q <= ds_rd;
                drv_q <= !rbyte[7];
                tx_q <= {rbyte[6:0], 1'b1};
              end
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
          ds_wr: begin
            if (cnt_q == 4'h7) begin
              cnt_q <= 4'h8;
              drv_q <= 1'b1;
              first_q <= 1'b0;
              off_q <= first_q ? sh_q : off_q + 8'h01;
            end else if (cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              drv_q <= 1'b0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
          ds_rd: begin
            if (cnt_q == 4'h7) begin
              cnt_q <= 4'h8;
              drv_q <= 1'b0;
            end else if (cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              drv_q <= !rbyte[7];
              tx_q <= {rbyte[6:0], 1'b1};
            end else begin
              cnt_q <= cnt_q + 4'h1;
              drv_q <= !tx_q[7];
              tx_q <= {tx_q[6:0], 1'b1};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign link.dev_sda_oe = {g_port[1].drv_q, g_port[0].drv_q};
  assign link.dev_sda_o = 2'h0;
  assign hs_mode = {g_port[1].hs_q, g_port[0].hs_q};
endmodule : dipsp_device
`default_nettype wire

// File: hdl/dipsp_host.sv
/*
  Host end: I2C bus master for either port, ordered byte by byte over APB.
  Assumes software sequences START, bytes and STOP, and sets high speed
  only after it has sent the master code.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dipsp_map.svh"
module dipsp_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dipsp_link_if.host link
);
  import dipsp_pkg::*;

  localparam logic [11:0] STD_DIV = 12'(`DIPSP_QTR(`DIPSP_STD_BPS));
  localparam logic [11:0] FS_MIN = 12'(`DIPSP_QTR(`DIPSP_FAST_BPS));
  localparam logic [11:0] HS_MIN = 12'(`DIPSP_QTR(`DIPSP_HS_BPS));

  dipsp_host_state_t st_q;
  dipsp_op_t op;
  logic [11:0] div_q;
  logic [11:0] eff_div;
  logic [11:0] cnt_q;
  logic port_q;
  logic bport_q;
  logic hs_q;
  logic ackn_q;
  logic wr_q;
  logic nack_q;
  logic [1:0] q_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic [1:0] scl_lo_q;
  logic [1:0] sda_lo_q;
  logic [1:0] sda_s;
  logic busy;
  logic tick;
  logic wr_fire;
  logic cmd_go;
  logic stop_done;

  dipsp_sync #(.W(2), .INIT(2'h3)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.sda_lvl),
    .q(sda_s)
  );

  // ==========================================================================
  // APB slave, zero wait states
  assign op = dipsp_op_t'(pwdata[`DIPSP_CMD_OP_LSB +: 3]);
  assign busy = (st_q != ms_idle);
  assign wr_fire = psel && penable && pready && pwrite;
  assign cmd_go = wr_fire && paddr == `DIPSP_CMD_OFS && !busy && op != op_none;
  assign stop_done = tick && st_q == ms_stop && q_q == 2'h2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `DIPSP_CTRL_OFS: prdata <= 32'({hs_q, port_q, div_q});
          `DIPSP_STAT_OFS: prdata <= 32'({hs_q, busy, nack_q, rx_q});
          `DIPSP_CMD_OFS: prdata <= 32'h0000_0000;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= STD_DIV;
      port_q <= 1'b0;
      hs_q <= 1'b0;
    end else if (stop_done) begin
      hs_q <= 1'b0;
    end else if (wr_fire && paddr == `DIPSP_CTRL_OFS) begin
      div_q <= pwdata[11:0];
      port_q <= pwdata[12];
      hs_q <= pwdata[13];
    end
  end

  // ==========================================================================
  // Quarter-bit pacing, never faster than the mode allows
  always_comb begin
    eff_div = div_q;
    if (div_q < (hs_q ? HS_MIN : FS_MIN)) begin
      eff_div = hs_q ? HS_MIN : FS_MIN;
    end
  end

  assign tick = busy && cnt_q == 12'h000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 12'h000;
    end else if (cmd_go || tick) begin
      cnt_q <= eff_div - 12'h001;
    end else if (busy) begin
      cnt_q <= cnt_q - 12'h001;
    end
  end

  // ==========================================================================
  // Bit sequencer: data bits move SDA only in quarter 0, while SCL is low; START and STOP move it in quarter 2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ms_idle;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      wr_q <= 1'b0;
      ackn_q <= 1'b0;
      nack_q <= 1'b0;
      bport_q <= 1'b0;
      scl_lo_q <= 2'h0;
      sda_lo_q <= 2'h0;
    end else if (cmd_go) begin
      case (op)
        op_start: st_q <= ms_start;
        op_stop: st_q <= ms_stop;
        op_write, op_read: st_q <= ms_byte;
        default: st_q <= ms_idle;
      endcase
      q_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= pwdata[7:0];
      wr_q <= (op == op_write);
      ackn_q <= pwdata[`DIPSP_CMD_ACKN_BIT];
      bport_q <= port_q;
    end else if (tick) begin
      q_q <= q_q + 2'h1;
      case (st_q)
        ms_start: begin
          case (q_q)
            2'h0: sda_lo_q[bport_q] <= 1'b0;
            2'h1: scl_lo_q[bport_q] <= 1'b0;
            2'h2: sda_lo_q[bport_q] <= 1'b1;
            default: begin
              scl_lo_q[bport_q] <= 1'b1;
              st_q <= ms_idle;
            end
          endcase
        end
        ms_stop: begin
          case (q_q)
            2'h0: sda_lo_q[bport_q] <= 1'b1;
            2'h1: scl_lo_q[bport_q] <= 1'b0;
            default: begin
              sda_lo_q[bport_q] <= 1'b0;
              st_q <= ms_idle;
            end
          endcase
        end
        ms_byte: begin
          case (q_q)
            2'h0: begin
              if (bit_q == 4'h8) begin
                sda_lo_q[bport_q] <= !wr_q && !ackn_q;
              end else begin
                sda_lo_q[bport_q] <= wr_q && !sh_q[7];
              end
            end
            2'h1: scl_lo_q[bport_q] <= 1'b0;
            2'h2: begin
              if (bit_q == 4'h8) begin
                nack_q <= wr_q ? sda_s[bport_q] : nack_q;
              end else begin
                sh_q <= {sh_q[6:0], sda_s[bport_q]};
              end
            end
            default: begin
              scl_lo_q[bport_q] <= 1'b1;
              if (bit_q == 4'h8) begin
                st_q <= ms_idle;
                rx_q <= sh_q;
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end
          endcase
        end
        default: st_q <= ms_idle;
      endcase
    end
  end

  assign link.host_scl_oe = scl_lo_q;
  assign link.host_scl_o = 2'h0;
  assign link.host_sda_oe = sda_lo_q;
  assign link.host_sda_o = 2'h0;
endmodule : dipsp_host
`default_nettype wire

// File: verif/dipsp_monitor.sv
/*
  Checker for the two open-drain links between host and device ends.
  Assumes it is instantiated beside the link interface, fed its plain signals.
*/
`timescale 1ns/10ps
`default_nettype none
module dipsp_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] host_scl_o,
  input wire logic [1:0] host_sda_o,
  input wire logic [1:0] dev_sda_o,
  input wire logic [1:0] dev_sda_oe,
  input wire logic [1:0] scl_lvl,
  input wire logic [1:0] sda_lvl
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ========================================================================
  // Line discipline
  property p_dev_open_drain;
    ((dev_sda_o & dev_sda_oe) == 2'b00) &&
      ((($past(dev_sda_oe) ^ dev_sda_oe) & scl_lvl) == 2'b00);
  endproperty
  a_dev_open_drain: assert property (p_dev_open_drain)
    else $error("device drove data high or moved it with clock high");
  property p_host_open_drain;
    ((host_scl_o | host_sda_o) == 2'b00) && (scl_lvl != 2'b00);
  endproperty
  a_host_open_drain: assert property (p_host_open_drain)
    else $error("host drove a line high or held both clocks low");
  // Device may move data only while the clock is low
  property p_cfg_hold;
    scl_lvl[0] && $past(scl_lvl[0]) |-> $stable(dev_sda_oe[0]);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config data moved while clock high");
  property p_scl_edge;
    $changed(dev_sda_oe[1]) |-> !scl_lvl[1] && !$past(scl_lvl[1]);
  endproperty
  a_scl_edge: assert property (p_scl_edge)
    else $error("scaling data moved near clock high");

  // ========================================================================
  // Framing
  property p_cfg_start_quiet;
    scl_lvl[0] && $past(scl_lvl[0]) && $fell(sda_lvl[0]) |-> !dev_sda_oe[0] [*8];
  endproperty
  a_cfg_start_quiet: assert property (p_cfg_start_quiet)
    else $error("config device pulled data during address");
  property p_scl_start_quiet;
    scl_lvl[1] && $past(scl_lvl[1]) && $fell(sda_lvl[1]) |-> !dev_sda_oe[1] [*8];
  endproperty
  a_scl_start_quiet: assert property (p_scl_start_quiet)
    else $error("scaling device pulled data during address");
  property p_cfg_stop_free;
    scl_lvl[0] && $past(scl_lvl[0]) && $rose(sda_lvl[0]) |=> !dev_sda_oe[0] [*8];
  endproperty
  a_cfg_stop_free: assert property (p_cfg_stop_free)
    else $error("config device held bus after stop");
  property p_scl_stop_free;
    scl_lvl[1] && $past(scl_lvl[1]) && $rose(sda_lvl[1]) |=> !dev_sda_oe[1] [*8];
  endproperty
  a_scl_stop_free: assert property (p_scl_stop_free)
    else $error("scaling device held bus after stop");

  c_cfg_ack: cover property (scl_lvl[0] && dev_sda_oe[0]);
  c_scl_ack: cover property (scl_lvl[1] && dev_sda_oe[1]);
  c_cfg_start: cover property (scl_lvl[0] && $fell(sda_lvl[0]));
endmodule : dipsp_monitor
`default_nettype wire

// File: verif/tb.sv
/*
  Testbench: host end over APB drives the device end through the link.
  Assumes the map header and package of the design are on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dipsp_map.svh"
module tb;
  import dipsp_pkg::*;
  logic pclk, presetn, sel, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, stat, rd;
  logic [3:0] remap;
  dipsp_port_vec_t hs;
  int bad_count, compares;

  dipsp_link_if u_dipsp_link_if ();
  dipsp_host u_dipsp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(u_dipsp_link_if));
  dipsp_device u_dipsp_device (.pclk(pclk), .presetn(presetn), .factory_i2c_sel(sel),
    .link(u_dipsp_link_if), .page_addr_remap_bits(remap), .hs_mode(hs));
  dipsp_monitor u_dipsp_monitor (.pclk(pclk), .presetn(presetn),
    .host_scl_o(u_dipsp_link_if.host_scl_o), .host_sda_o(u_dipsp_link_if.host_sda_o),
    .dev_sda_o(u_dipsp_link_if.dev_sda_o), .dev_sda_oe(u_dipsp_link_if.dev_sda_oe),
    .scl_lvl(u_dipsp_link_if.scl_lvl), .sda_lvl(u_dipsp_link_if.sda_lvl));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ========================================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("Counts: compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic hang();
    bad_count++;
    $display("BAD wait expected done seen timeout");
    tally_and_finish();
  endtask : hang
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One idle cycle after each transfer keeps strobes from two writes in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cmd(input dipsp_op_t op, input logic [7:0] b = 8'h00, input logic k = 1'b0);
    int n;
    apb(1'b1, `DIPSP_CMD_OFS, {20'h0, k, op, b});
    n = 0;
    do begin
      apb(1'b0, `DIPSP_STAT_OFS, 32'h0);
      n++;
    end while (rd[9] !== 1'b0 && n < 2000);
    if (n >= 2000) hang();
    stat = rd;
  endtask : cmd
  task automatic ctrl(input logic [11:0] div, input logic port, input logic hsb);
    apb(1'b1, `DIPSP_CTRL_OFS, {18'h0, hsb, port, div});
  endtask : ctrl
  task automatic addr(input logic [6:0] a, input logic dir, input logic nack);
    cmd(op_start);
    cmd(op_write, {a, dir});
    chk("addr nack", {7'h0, nack}, {7'h0, stat[8]});
  endtask : addr
  task automatic probe(input logic [6:0] a, input logic nack);
    addr(a, 1'b1, nack);
    cmd(op_stop);
  endtask : probe
  task automatic wr2(input logic [6:0] a, input logic [7:0] ofs, d0, d1);
    addr(a, 1'b1, 1'b0);
    cmd(op_write, ofs);
    cmd(op_write, d0);
    cmd(op_write, d1);
    chk("data nack", 8'h00, {7'h0, stat[8]});
    cmd(op_stop);
  endtask : wr2
  task automatic rd2(input logic [6:0] a, input logic [7:0] ofs, e0, e1);
    addr(a, 1'b1, 1'b0);
    cmd(op_write, ofs);
    addr(a, 1'b0, 1'b0);
    cmd(op_read);
    chk("rx first", e0, stat[7:0]);
    cmd(op_read, 8'h00, 1'b1);
    chk("rx next", e1, stat[7:0]);
    cmd(op_stop);
  endtask : rd2

  // ========================================================================
  // Scenarios
  task automatic t_strap();
    ctrl(12'd16, 1'b0, 1'b0);
    probe(7'h48, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 8'h01, {7'h0, err});
    sel <= 1'b1;
    repeat (4) @(posedge pclk);
    $display("test strap done");
  endtask : t_strap
  task automatic t_cfg();
    wr2(7'h48, 8'h03, 8'hA5, 8'h5A);
    rd2(7'h48, 8'h03, 8'hA5, 8'h5A);
    rd2(7'h48, 8'h0F, 8'h00, `DIPSP_UNDEF_BYTE);
    for (int i = 0; i < 4; i++) probe(`DIPSP_CFG_BASE + 7'(i), 1'b0);
    probe(7'h4C, 1'b1);
    probe(7'h00, 1'b1);
    probe(7'h78, 1'b1);
    $display("test cfg done");
  endtask : t_cfg
  task automatic t_remap();
    wr2(7'h4A, 8'h00, 8'h11, 8'h22);
    wr2(7'h49, `DIPSP_REMAP_OFS, 8'h04, 8'h00);
    chk("remap", 8'h04, {4'h0, remap});
    probe(7'h4A, 1'b1);
    rd2(7'h5A, 8'h00, 8'h11, 8'h22);
    probe(7'h48, 1'b0);
    wr2(7'h49, `DIPSP_REMAP_OFS, 8'hFF, 8'h00);
    rd2(7'h59, `DIPSP_REMAP_OFS, 8'h1F, 8'h00);
    probe(7'h58, 1'b0);
    probe(7'h5B, 1'b0);
    probe(7'h48, 1'b1);
    wr2(7'h59, `DIPSP_REMAP_OFS, `DIPSP_REMAP_RST, 8'h00);
    chk("remap", 8'h00, {4'h0, remap});
    $display("test remap done");
  endtask : t_remap
  task automatic t_scale();
    ctrl(12'd16, 1'b1, 1'b0);
    wr2(`DIPSP_SCALE_ADDR, 8'h01, 8'h3C, 8'hC3);
    rd2(`DIPSP_SCALE_ADDR, 8'h01, 8'h3C, 8'hC3);
    probe(7'h48, 1'b1);
    ctrl(12'd16, 1'b0, 1'b0);
    probe(`DIPSP_SCALE_ADDR, 1'b1);
    rd2(7'h48, 8'h01, 8'h00, 8'h00);
    $display("test scale done");
  endtask : t_scale
  task automatic t_hs();
    cmd(op_start);
    cmd(op_write, 8'h08);
    chk("code nack", 8'h01, {7'h0, stat[8]});
    chk("hs on", 8'h01, {6'h0, hs});
    ctrl(12'd4, 1'b0, 1'b1);
    rd2(7'h48, 8'h03, 8'hA5, 8'h5A);
    chk("hs off", 8'h00, {6'h0, hs});
    ctrl(12'd16, 1'b0, 1'b0);
    $display("test hs done");
  endtask : t_hs

  initial begin
    presetn = 1'b0;
    sel = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bad_count = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_strap();
    t_cfg();
    t_remap();
    t_scale();
    t_hs();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
